//--- logic/synth_ctrl_pkg.sv
// Constants for the dual-loop synthesizer digital control block.
// Assumes a 250 MHz system clock and a three-wire programming link.
package synth_ctrl_pkg;
   localparam int WORD_W        = 24;
   localparam int DIV_W         = 16;
   localparam int CLK_PERIOD_PS = 4000;
   // Destination bits, word[1:0]
   localparam logic [1:0] DEST_LOW_R  = 2'h0;
   localparam logic [1:0] DEST_LOW_N  = 2'h1;
   localparam logic [1:0] DEST_HIGH_R = 2'h2;
   localparam logic [1:0] DEST_HIGH_N = 2'h3;
   // Control bits: 23 and 22 in both N words; 21 is sync mode in low N, prescaler in high N
   localparam int POS_CNT_RST  = 23;
   localparam int POS_PWDN     = 22;
   localparam int POS_PD_SYNC  = 21;
   localparam int POS_PRESC    = 21;
   // Low loop N word
   localparam int POS_RAPID    = 20;
   localparam int POS_TEST     = 19;
   localparam int POS_OUT2     = 18;
   localparam int POS_GP_OUT_SECOND_PIN     = 17;
   localparam int LOW_B_LSB    = 5;
   localparam int LOW_B_W      = 12;
   localparam int LOW_A_LSB    = 2;
   localparam int LOW_A_W      = 3;
   localparam int LOW_PRESC    = 8;
   // High loop N word
   localparam int HIGH_B_LSB   = 11;
   localparam int HIGH_B_W     = 10;
   localparam int HIGH_A_LSB   = 6;
   localparam int HIGH_A_W     = 5;
   localparam int FRAC_LSB     = 2;
   localparam int FRAC_W       = 4;
   // R words
   localparam int POS_LOW_GAIN8 = 18;
   localparam int POS_HIGH_CP8  = 21;
   localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;
   // Lock filter
   localparam int LOCK_ENTER_PS = 15000;
   localparam int LOCK_EXIT_PS  = 30000;
   localparam int LOCK_ENTER_CYC = (LOCK_ENTER_PS / CLK_PERIOD_PS < 1) ? 1
                                   : LOCK_ENTER_PS / CLK_PERIOD_PS;
   localparam int LOCK_EXIT_CYC  = LOCK_EXIT_PS / CLK_PERIOD_PS;
   localparam int LOCK_CYCLES    = 5;
endpackage

//--- logic/synth_divider_control.sv
// Contract
// - Counter-reset bit set holds that loop's feedback and reference counters in reset.
// - After reset or power-down both counters restart together, within one prescaler cycle.
// - Power-down disables loop dividers and puts its RF input in high impedance.
// - Reference input goes high impedance only when both loops are powered down.
// - Powered-down loop has its pump and phase comparator in high impedance.
// - Serial register shifts and latches in every power-down state.
// - Low N bit 21 selects synchronous power-down; host loads it before bit 22.
// - Synchronous mode enters power-down after the current pump pulse ends.
// - Asynchronous mode enters power-down as soon as the bit is latched.
// - Prescaler select: high range 16/17 or 32/33, low range 8/9 or 16/17.
// - Fraction accumulator adds value over modulus 15 or 16 each cycle.
// - Feedback divide equals modulus times program count plus swallow count.
// - Without rapid lock, low N bits 17 and 18 set the two output levels.
// - Low N bit 20 selects rapid lock; level bits then ignored.
// - Rapid lock: first output low while high pump 8x bit set, else released.
// - Rapid lock: second output low while low pump gain bit set, else released.
// - Words arrive MSB first, shifted on serial clock rising edge.
// - Lock asserts after five reference cycles with phase error below 15 ns.
// - Locked threshold widens to 30 ns; lock drops when error exceeds it.
// - Lock forced low while its loop is powered down.
// - Two trailing bits pick destination: 01 low N, 10 high R, 11 high N.
// - Low R bit 18 selects low loop pump gain, one or eight times.
// Holds the serial front end, both loops' dividers, phase detectors and lock filters.
// Assumes osc_tick and vco_tick are one-cycle pulses on clk; link pins are asynchronous.
`timescale 1ns/1ps
module synth_divider_control #(
   parameter bit          HIGH_RANGE   = 1'b1,
   parameter bit          FRAC_MOD16   = 1'b1,
   parameter logic [15:0] LOW_REF_DIV  = 16'h0010,
   parameter logic [15:0] HIGH_REF_DIV = 16'h0010
) (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       ser_clk,
   input  wire logic       ser_data,
   input  wire logic       latch_enable_line,
   input  wire logic       osc_tick,
   input  wire logic [1:0] vco_tick,
   output logic [1:0]      rf_input_hiz,
   output logic            reference_osc_hiz,
   output logic [1:0]      pump_hiz,
   output logic [1:0]      pump_up,
   output logic [1:0]      pump_down,
   output logic [1:0]      lock_indicator_pin,
   output logic            gp_out_first_pin,
   output logic            gp_out_first_oe,
   output logic            gp_out_second_pin,
   output logic            gp_out_second_oe
);
   localparam int W = synth_ctrl_pkg::WORD_W;
   localparam int D = synth_ctrl_pkg::DIV_W;

   // Link synchronisers; stage one feeds only stage two
   logic [2:0] sync1_ff, sync2_ff;
   logic       sclk_prev_ff, le_prev_ff;
   logic [W-1:0] shift_ff, nxt_shift;
   logic [W-1:0] low_n_ff, high_n_ff, high_r_ff, low_r_ff;
   logic [W-1:0] nxt_low_n, nxt_high_n, nxt_high_r, nxt_low_r;

   always_comb begin
      nxt_shift  = shift_ff;
      nxt_low_n  = low_n_ff;
      nxt_high_n = high_n_ff;
      nxt_high_r = high_r_ff;
      nxt_low_r  = low_r_ff;
      // Never gated by power-down
      if (sync2_ff[0] && !sclk_prev_ff) begin
         nxt_shift = {shift_ff[W-2:0], sync2_ff[1]};
      end
      if (sync2_ff[2] && !le_prev_ff) begin
         case (shift_ff[1:0])
            synth_ctrl_pkg::DEST_LOW_N:  nxt_low_n  = shift_ff;
            synth_ctrl_pkg::DEST_HIGH_N: nxt_high_n = shift_ff;
            synth_ctrl_pkg::DEST_HIGH_R: nxt_high_r = shift_ff;
            default:                     nxt_low_r  = shift_ff;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_ff     <= 3'h0;
         sync2_ff     <= 3'h0;
         sclk_prev_ff <= 1'b0;
         le_prev_ff   <= 1'b0;
         shift_ff     <= synth_ctrl_pkg::WORD_RESET;
         low_n_ff     <= synth_ctrl_pkg::WORD_RESET;
         high_n_ff    <= synth_ctrl_pkg::WORD_RESET;
         high_r_ff    <= synth_ctrl_pkg::WORD_RESET;
         low_r_ff     <= synth_ctrl_pkg::WORD_RESET;
      end else begin
         sync1_ff     <= {latch_enable_line, ser_data, ser_clk};
         sync2_ff     <= sync1_ff;
         sclk_prev_ff <= sync2_ff[0];
         le_prev_ff   <= sync2_ff[2];
         shift_ff     <= nxt_shift;
         low_n_ff     <= nxt_low_n;
         high_n_ff    <= nxt_high_n;
         high_r_ff    <= nxt_high_r;
         low_r_ff     <= nxt_low_r;
      end
   end

   // Word fields; index 0 is the low loop, 1 the high loop
   logic [1:0] cnt_rst, pd_req;
   logic       pd_sync;
   logic [D-1:0] div_base [2];
   logic [4:0]   pmod;
   logic [3:0]   frac;
   logic [4:0]   fmod;

   always_comb begin
      cnt_rst = {high_n_ff[synth_ctrl_pkg::POS_CNT_RST], low_n_ff[synth_ctrl_pkg::POS_CNT_RST]};
      pd_req  = {high_n_ff[synth_ctrl_pkg::POS_PWDN], low_n_ff[synth_ctrl_pkg::POS_PWDN]};
      pd_sync = low_n_ff[synth_ctrl_pkg::POS_PD_SYNC];
      // 5-bit carrier for 8, 16 or 32 with 32 as zero shifted; compute as shift amount
      pmod = high_n_ff[synth_ctrl_pkg::POS_PRESC] ? (HIGH_RANGE ? 5'h5 : 5'h4)
                                                  : (HIGH_RANGE ? 5'h4 : 5'h3);
      div_base[0] = D'(synth_ctrl_pkg::LOW_PRESC
                    * low_n_ff[synth_ctrl_pkg::LOW_B_LSB +: synth_ctrl_pkg::LOW_B_W])
                  + D'(low_n_ff[synth_ctrl_pkg::LOW_A_LSB +: synth_ctrl_pkg::LOW_A_W]);
      div_base[1] = (D'(high_n_ff[synth_ctrl_pkg::HIGH_B_LSB +: synth_ctrl_pkg::HIGH_B_W])
                    << pmod)
                  + D'(high_n_ff[synth_ctrl_pkg::HIGH_A_LSB +: synth_ctrl_pkg::HIGH_A_W]);
      frac = high_n_ff[synth_ctrl_pkg::FRAC_LSB +: synth_ctrl_pkg::FRAC_W];
      fmod = FRAC_MOD16 ? 5'h10 : 5'h0F;
   end

   // Divider, phase detector, power and lock state per loop
   logic [D-1:0] ref_cnt_ff [2], nxt_ref_cnt [2];
   logic [D-1:0] fb_cnt_ff [2], nxt_fb_cnt [2];
   logic [4:0]   acc_ff, nxt_acc;
   logic [1:0]   ref_seen_ff, fb_seen_ff, pd_ff, lock_ff;
   logic [1:0]   nxt_ref_seen, nxt_fb_seen, nxt_pd, nxt_lock;
   logic [3:0]   err_ff [2], nxt_err [2];
   logic [2:0]   good_ff [2], nxt_good [2];
   logic [1:0]   held, busy, ref_tc, fb_tc, done;
   logic [D-1:0] div_now;
   logic [4:0]   acc_sum;
   logic [3:0]   thr;

   always_comb begin
      acc_sum = acc_ff + 5'(frac);
      nxt_acc = acc_ff;
      for (int i = 0; i < 2; i++) begin
         held[i] = cnt_rst[i] | pd_ff[i];
         busy[i] = ref_seen_ff[i] ^ fb_seen_ff[i];
         nxt_ref_cnt[i] = ref_cnt_ff[i];
         nxt_fb_cnt[i]  = fb_cnt_ff[i];
         ref_tc[i] = 1'b0;
         fb_tc[i]  = 1'b0;
         div_now = div_base[i];
         if (i == 1 && acc_sum >= fmod) begin
            div_now = div_base[i] + D'(1);
         end
         if (held[i]) begin
            // Both restart from zero together on release
            nxt_ref_cnt[i] = '0;
            nxt_fb_cnt[i]  = '0;
         end else begin
            if (osc_tick) begin
               ref_tc[i] = ref_cnt_ff[i] == (i == 0 ? LOW_REF_DIV : HIGH_REF_DIV) - D'(1);
               nxt_ref_cnt[i] = ref_tc[i] ? '0 : ref_cnt_ff[i] + D'(1);
            end
            if (vco_tick[i]) begin
               fb_tc[i] = fb_cnt_ff[i] >= div_now - D'(1);
               nxt_fb_cnt[i] = fb_tc[i] ? '0 : fb_cnt_ff[i] + D'(1);
               if (i == 1 && fb_tc[i]) begin
                  nxt_acc = (acc_sum >= fmod) ? acc_sum - fmod : acc_sum;
               end
            end
         end
         // Phase detector: pump runs between the two edges
         nxt_ref_seen[i] = ref_seen_ff[i] | ref_tc[i];
         nxt_fb_seen[i]  = fb_seen_ff[i] | fb_tc[i];
         done[i] = nxt_ref_seen[i] & nxt_fb_seen[i];
         nxt_err[i] = busy[i] && err_ff[i] != 4'hF ? err_ff[i] + 4'h1 : err_ff[i];
         if (done[i] || held[i]) begin
            nxt_ref_seen[i] = 1'b0;
            nxt_fb_seen[i]  = 1'b0;
            nxt_err[i]      = 4'h0;
         end
         // Power-down entry
         nxt_pd[i] = 1'b0;
         if (pd_req[i]) begin
            nxt_pd[i] = pd_ff[i] | !pd_sync | !busy[i];
         end
         // Lock filter
         nxt_lock[i] = lock_ff[i];
         nxt_good[i] = good_ff[i];
         thr = lock_ff[i] ? 4'(synth_ctrl_pkg::LOCK_EXIT_CYC)
                          : 4'(synth_ctrl_pkg::LOCK_ENTER_CYC);
         if (done[i] && !held[i]) begin
            if (lock_ff[i]) begin
               if (err_ff[i] > thr) begin
                  nxt_lock[i] = 1'b0;
                  nxt_good[i] = 3'h0;
               end
            end else if (err_ff[i] < thr) begin
               nxt_good[i] = good_ff[i] + 3'h1;
               if (nxt_good[i] == 3'(synth_ctrl_pkg::LOCK_CYCLES)) begin
                  nxt_lock[i] = 1'b1;
               end
            end else begin
               nxt_good[i] = 3'h0;
            end
         end
         if (nxt_pd[i]) begin
            nxt_lock[i] = 1'b0;
            nxt_good[i] = 3'h0;
         end
      end
      if (held[1]) begin
         nxt_acc = 5'h00;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 2; i++) begin
            ref_cnt_ff[i] <= '0;
            fb_cnt_ff[i]  <= '0;
            err_ff[i]     <= 4'h0;
            good_ff[i]    <= 3'h0;
         end
         acc_ff      <= 5'h00;
         ref_seen_ff <= 2'h0;
         fb_seen_ff  <= 2'h0;
         pd_ff       <= 2'h0;
         lock_ff     <= 2'h0;
      end else begin
         ref_cnt_ff  <= nxt_ref_cnt;
         fb_cnt_ff   <= nxt_fb_cnt;
         err_ff      <= nxt_err;
         good_ff     <= nxt_good;
         acc_ff      <= nxt_acc;
         ref_seen_ff <= nxt_ref_seen;
         fb_seen_ff  <= nxt_fb_seen;
         pd_ff       <= nxt_pd;
         lock_ff     <= nxt_lock;
      end
   end

   // Pin stage; every output registered
   logic rapid;
   logic nxt_first_pin, nxt_first_oe, nxt_second_pin, nxt_second_oe;

   always_comb begin
      rapid = low_n_ff[synth_ctrl_pkg::POS_RAPID];
      if (rapid) begin
         nxt_first_pin  = 1'b0;
         nxt_first_oe   = high_r_ff[synth_ctrl_pkg::POS_HIGH_CP8];
         nxt_second_pin = 1'b0;
         nxt_second_oe  = low_r_ff[synth_ctrl_pkg::POS_LOW_GAIN8];
      end else begin
         nxt_first_pin  = low_n_ff[synth_ctrl_pkg::POS_GP_OUT_SECOND_PIN];
         nxt_first_oe   = 1'b1;
         nxt_second_pin = low_n_ff[synth_ctrl_pkg::POS_OUT2];
         nxt_second_oe  = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rf_input_hiz       <= 2'h0;
         reference_osc_hiz  <= 1'b0;
         pump_hiz           <= 2'h0;
         pump_up            <= 2'h0;
         pump_down          <= 2'h0;
         lock_indicator_pin <= 2'h0;
         gp_out_first_pin   <= 1'b0;
         gp_out_first_oe    <= 1'b1;
         gp_out_second_pin  <= 1'b0;
         gp_out_second_oe   <= 1'b1;
      end else begin
         rf_input_hiz       <= nxt_pd;
         reference_osc_hiz  <= &nxt_pd;
         pump_hiz           <= nxt_pd;
         pump_up            <= nxt_ref_seen & ~nxt_fb_seen & ~nxt_pd;
         pump_down          <= nxt_fb_seen & ~nxt_ref_seen & ~nxt_pd;
         lock_indicator_pin <= nxt_lock;
         gp_out_first_pin   <= nxt_first_pin;
         gp_out_first_oe    <= nxt_first_oe;
         gp_out_second_pin  <= nxt_second_pin;
         gp_out_second_oe   <= nxt_second_oe;
      end
   end

   property p_cnt_rst;
      @(posedge clk) disable iff (!arst_n)
      cnt_rst[0] |=> fb_cnt_ff[0] == '0 && ref_cnt_ff[0] == '0;
   endproperty
   a_cnt_rst: assert property (p_cnt_rst) else $error("counter not held");
   property p_async_pd;
      @(posedge clk) disable iff (!arst_n)
      pd_req[0] && !pd_sync |=> pd_ff[0] && rf_input_hiz[0] && pump_hiz[0];
   endproperty
   a_async_pd: assert property (p_async_pd) else $error("async power-down late");
   property p_sync_pd;
      @(posedge clk) disable iff (!arst_n)
      pd_req[0] && pd_sync && !pd_ff[0] && busy[0] |=> !pd_ff[0];
   endproperty
   a_sync_pd: assert property (p_sync_pd) else $error("pump cut short");
   property p_osc_hiz;
      @(posedge clk) disable iff (!arst_n) reference_osc_hiz |-> $past(pd_req) == 2'h3;
   endproperty
   a_osc_hiz: assert property (p_osc_hiz) else $error("osc high-z wrong");
   property p_lock_pd;
      @(posedge clk) disable iff (!arst_n) pd_ff[0] |-> !lock_indicator_pin[0];
   endproperty
   a_lock_pd: assert property (p_lock_pd) else $error("lock in power-down");
   property p_lock_enter;
      @(posedge clk) disable iff (!arst_n)
      $rose(lock_ff[1]) |-> $past(good_ff[1]) == 3'h4;
   endproperty
   a_lock_enter: assert property (p_lock_enter) else $error("lock too early");
   property p_rapid;
      @(posedge clk) disable iff (!arst_n)
      rapid |=> !gp_out_first_pin
      && gp_out_first_oe == $past(high_r_ff[synth_ctrl_pkg::POS_HIGH_CP8]);
   endproperty
   a_rapid: assert property (p_rapid) else $error("rapid output wrong");
   property p_latch;
      @(posedge clk) disable iff (!arst_n)
      sync2_ff[2] && !le_prev_ff && shift_ff[1:0] == synth_ctrl_pkg::DEST_HIGH_N
      |=> high_n_ff == $past(shift_ff);
   endproperty
   a_latch: assert property (p_latch) else $error("word not latched");
   c_lock:  cover property (@(posedge clk) disable iff (!arst_n) $rose(lock_ff[1]));
   c_unlock: cover property (@(posedge clk) disable iff (!arst_n) $fell(lock_ff[0]));
   c_sync:  cover property (@(posedge clk) disable iff (!arst_n) pd_sync && $rose(pd_ff[0]));
endmodule

//--- test/host_link_model.sv
// Host side of the three-wire programming link.
// Assumes the caller waits for send_word to return before sending again.
`timescale 1ns/1ps
module host_link_model (
   output logic ser_clk,
   output logic ser_data,
   output logic latch_enable_line
);
   real half_ns;

   initial begin
      half_ns           = 62.5;
      ser_clk           = 1'b0;
      ser_data          = 1'b0;
      latch_enable_line = 1'b0;
   end

   // Clock idles low between words; data is inverted after a word so a
   // stale bit is never mistaken for a held one
   task automatic send_word(input logic [23:0] word);
      for (int i = 23; i >= 0; i--) begin
         ser_data = word[i];
         #(half_ns) ser_clk = 1'b1;
         #(half_ns) ser_clk = 1'b0;
      end
      #(half_ns) latch_enable_line = 1'b1;
      #(half_ns) latch_enable_line = 1'b0;
      ser_data = ~word[0];
   endtask
endmodule

//--- test/testbench.sv
// Self-checking bench for the synthesizer control block.
// Assumes host_link_model drives the link pins; ticks come from this bench.
`timescale 1ns/1ps
module testbench;
   logic        clk;
   logic        arst_n;
   logic        ser_clk;
   logic        ser_data;
   logic        latch_enable_line;
   logic        osc_tick;
   logic [1:0]  vco_tick;
   logic [1:0]  rf_input_hiz;
   logic        reference_osc_hiz;
   logic [1:0]  pump_hiz;
   logic [1:0]  pump_up;
   logic [1:0]  pump_down;
   logic [1:0]  lock_indicator_pin;
   logic        gp_out_first_pin;
   logic        gp_out_first_oe;
   logic        gp_out_second_pin;
   logic        gp_out_second_oe;
   logic [3:0]  gp;
   logic [23:0] hw [2];
   int          fail_count;
   int          checks;
   int          n;

   assign gp = {gp_out_first_oe, gp_out_second_oe, gp_out_first_pin, gp_out_second_pin};

   // Reference counts sized so every loop divide below comes out equal
   synth_divider_control #(
      .HIGH_RANGE   (1'b1),
      .FRAC_MOD16   (1'b1),
      .LOW_REF_DIV  (16'h0018),
      .HIGH_REF_DIV (16'h0061)
   ) i_synth_divider_control (
      .clk                (clk),
      .arst_n             (arst_n),
      .ser_clk            (ser_clk),
      .ser_data           (ser_data),
      .latch_enable_line  (latch_enable_line),
      .osc_tick           (osc_tick),
      .vco_tick           (vco_tick),
      .rf_input_hiz       (rf_input_hiz),
      .reference_osc_hiz  (reference_osc_hiz),
      .pump_hiz           (pump_hiz),
      .pump_up            (pump_up),
      .pump_down          (pump_down),
      .lock_indicator_pin (lock_indicator_pin),
      .gp_out_first_pin   (gp_out_first_pin),
      .gp_out_first_oe    (gp_out_first_oe),
      .gp_out_second_pin  (gp_out_second_pin),
      .gp_out_second_oe   (gp_out_second_oe)
   );

   host_link_model i_host_link_model (
      .ser_clk           (ser_clk),
      .ser_data          (ser_data),
      .latch_enable_line (latch_enable_line)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic wrap_up;
      $display("checks=%0d mismatches=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Margin after the word covers synchroniser and latch delay
   task automatic put(input logic [23:0] w);
      i_host_link_model.send_word(w);
      repeat (8) @(negedge clk);
   endtask

   initial begin
      #200000;
      fail_count++;
      $display("[ERR] t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
      wrap_up();
   end

   initial begin
      fail_count = 0;
      checks     = 0;
      arst_n     = 1'b0;
      osc_tick   = 1'b0;
      vco_tick   = 2'h0;
      hw         = '{24'h003043, 24'h201843};
      repeat (4) @(negedge clk);
      chk(8'(gp), 8'h0C);
      chk(8'({reference_osc_hiz, rf_input_hiz, pump_hiz}), 8'h00);
      chk(8'({pump_up, pump_down, lock_indicator_pin}), 8'h00);
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         put({5'h00, i[1:0], 17'h00061});
         chk(8'(gp), 8'({2'b11, i[0], i[1]}));
      end
      $display("test output levels done");
      put(24'h160061);
      chk(8'(gp[3:2]), 8'h00);
      put(24'h200002);
      chk(8'({gp[3], gp[1]}), 8'h02);
      put(24'h040000);
      chk(8'({gp[2], gp[0]}), 8'h02);
      put(24'h000002);
      chk(8'(gp[3]), 8'h00);
      put(24'h000000);
      chk(8'(gp[2]), 8'h00);
      put(24'h000061);
      chk(8'(gp), 8'h0C);
      $display("test rapid lock done");
      put(24'h400061);
      chk(8'({reference_osc_hiz, rf_input_hiz, pump_hiz, lock_indicator_pin[0]}), 8'h0A);
      put(24'h403043);
      chk(8'({reference_osc_hiz, rf_input_hiz}), 8'h07);
      put(24'h420061);
      chk(8'(gp), 8'h0E);
      put(24'h000061);
      put(24'h003043);
      chk(8'({reference_osc_hiz, rf_input_hiz, pump_hiz}), 8'h00);
      $display("test power down done");
      osc_tick = 1'b1;
      vco_tick = 2'h3;
      foreach (hw[k]) begin
         put(hw[k] | 24'h400000);
         chk(8'({rf_input_hiz[1], lock_indicator_pin[1]}), 8'h02);
         put(hw[k]);
         for (n = 0; n < 1500 && lock_indicator_pin[1] !== 1'b1; n++) @(negedge clk);
         chk(8'(lock_indicator_pin[1]), 8'h01);
      end
      chk(8'(lock_indicator_pin[0]), 8'h01);
      $display("test divide and lock done");
      // Offset of 5 cycles sits between the two thresholds
      vco_tick[0] = 1'b0;
      repeat (5) @(negedge clk);
      vco_tick[0] = 1'b1;
      n = 0;
      repeat (300) begin
         @(negedge clk);
         if (lock_indicator_pin[0] !== 1'b1) n++;
      end
      chk(8'(n), 8'h00);
      vco_tick[0] = 1'b0;
      repeat (20) @(negedge clk);
      vco_tick[0] = 1'b1;
      for (n = 0; n < 100 && lock_indicator_pin[0] !== 1'b0; n++) @(negedge clk);
      chk(8'(lock_indicator_pin[0]), 8'h00);
      $display("test lock hysteresis done");
      put(24'h800061);
      n = 0;
      repeat (200) begin
         @(negedge clk);
         if ((pump_up[0] | pump_down[0]) !== 1'b0) n++;
      end
      chk(8'(n), 8'h00);
      put(24'h000061);
      $display("test counter reset done");
      // Feedback stalled keeps the pump pulse open
      vco_tick[0] = 1'b0;
      put(24'h200061);
      chk(8'(pump_up[0]), 8'h01);
      put(24'h600061);
      chk(8'(rf_input_hiz[0]), 8'h00);
      vco_tick[0] = 1'b1;
      for (n = 0; n < 60 && rf_input_hiz[0] !== 1'b1; n++) @(negedge clk);
      chk(8'({rf_input_hiz[0], pump_hiz[0]}), 8'h03);
      put(24'h000061);
      $display("test sync power down done");
      wrap_up();
   end
endmodule
